// >>> rtl/sdsu_top.sv
`timescale 1ns/1ps
`default_nettype none

module sdsu_top
   import sdsu_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Split transaction engine results
   input  wire logic        xr_done,
   input  wire logic [2:0]  xr_code,
   input  wire logic [14:0] xr_bytes,
   input  wire logic        xr_toggle,
   input  wire logic        frame_start,
   input  wire logic        frame_short,
   // Descriptor state toward the scheduler
   output var  logic        desc_valid,
   output var  logic        desc_in_use,
   output var  logic        hold_async_ptr,
   // Interrupt
   output var  logic        irq
);

   // ==========================================================
   // Internal state
   // ==========================================================
   logic [31:0]         status;
   logic [3:0]          reload;
   logic                iso;
   logic [1:0]          retry_init;
   logic [SDSU_IRQ_W-1:0] irq_stat;
   logic [SDSU_IRQ_W-1:0] irq_mask;
   logic [SDSU_IRQ_W-1:0] next_events;
   logic                retire_pend;
   logic                retry_pend;
   logic                next_retire;
   logic                next_retry;
   logic                next_valid_drop;
   logic [31:0]         next_status;

   logic                wr_en;
   logic                rd_en;
   logic                hit;
   logic [31:0]         rd_mux;
   sdsu_res_t           res;

   assign res = sdsu_res_t'(xr_code);

   // ==========================================================
   // APB decode
   // ==========================================================
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_en = psel & penable & ~pready;

   always_comb
   begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         SDSU_OFS_STATUS:   rd_mux = status;
         SDSU_OFS_CONFIG:
         begin
            rd_mux[SDSU_B_VALID]                       = desc_valid;
            rd_mux[SDSU_B_RELOAD_HI:SDSU_B_RELOAD_LO]  = reload;
            rd_mux[SDSU_B_ISO]                         = iso;
         end
         SDSU_OFS_IRQ_STAT: rd_mux[SDSU_IRQ_W-1:0] = irq_stat;
         SDSU_OFS_IRQ_MASK: rd_mux[SDSU_IRQ_W-1:0] = irq_mask;
         default:           hit = 1'b0;
      endcase
   end

   // One wait state: pready rises the cycle after access begins
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= rd_en;
         pslverr <= rd_en & ~hit;
         if (rd_en)
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
   end

   // ==========================================================
   // Outcome evaluation
   // ==========================================================
   always_comb
   begin
      next_status     = status;
      next_events     = '0;
      next_retire     = 1'b0;
      next_retry      = 1'b0;
      next_valid_drop = 1'b0;
      if (xr_done && desc_valid)
      begin
         case (res)
            SDSU_RES_ACK:
            begin
               next_status[SDSU_B_TOGGLE] = xr_toggle;
               next_status[SDSU_B_BYTES_HI:SDSU_B_BYTES_LO] = xr_bytes;
               next_status[SDSU_B_XACT_ERR] = 1'b0;
               next_valid_drop = 1'b1;
               next_retire     = 1'b1;
               next_events[SDSU_IRQ_DONE] = 1'b1;
            end
            SDSU_RES_NAK, SDSU_RES_NYET:
            begin
               next_status[SDSU_B_RETRY_HI:SDSU_B_RETRY_LO] = retry_init;
               if (!iso && reload != 4'h0)
               begin
                  if (status[SDSU_B_NAK_HI:SDSU_B_NAK_LO] <= 4'h1)
                  begin
                     next_status[SDSU_B_NAK_HI:SDSU_B_NAK_LO] = 4'h0;
                     next_valid_drop = 1'b1;
                     next_retire     = 1'b1;
                     next_events[SDSU_IRQ_NAK_OUT] = 1'b1;
                  end
                  else
                     next_status[SDSU_B_NAK_HI:SDSU_B_NAK_LO] =
                        status[SDSU_B_NAK_HI:SDSU_B_NAK_LO] - 4'h1;
               end
            end
            SDSU_RES_NORESP:
            begin
               next_status[SDSU_B_XACT_ERR] = 1'b1;
               next_events[SDSU_IRQ_XACT_ERR] = 1'b1;
               if (status[SDSU_B_RETRY_HI:SDSU_B_RETRY_LO] <= 2'h1)
               begin
                  next_status[SDSU_B_RETRY_HI:SDSU_B_RETRY_LO] = 2'h0;
                  next_valid_drop = 1'b1;
                  next_retire     = 1'b1;
               end
               else
               begin
                  next_status[SDSU_B_RETRY_HI:SDSU_B_RETRY_LO] =
                     status[SDSU_B_RETRY_HI:SDSU_B_RETRY_LO] - 2'h1;
                  next_retry = 1'b1;
               end
            end
            SDSU_RES_BABBLE:
            begin
               next_status[SDSU_B_BABBLE] = 1'b1;
               next_status[SDSU_B_BYTES_HI:SDSU_B_BYTES_LO] = xr_bytes;
               next_valid_drop = 1'b1;
               next_retire     = 1'b1;
               next_events[SDSU_IRQ_BABBLE] = 1'b1;
            end
            SDSU_RES_STALL:
            begin
               next_status[SDSU_B_STOP] = 1'b1;
               next_valid_drop = 1'b1;
               next_retire     = 1'b1;
               next_events[SDSU_IRQ_HALT] = 1'b1;
            end
            default:
            begin
               next_status = status;
            end
         endcase
      end
   end

   // ==========================================================
   // Status word
   // ==========================================================
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         status <= SDSU_RST_STATUS;
      else if (xr_done && desc_valid)
         status <= next_status;
      else if (retire_pend)
         status[SDSU_B_IN_USE] <= 1'b0;
      else if (wr_en && paddr == SDSU_OFS_STATUS)
         status <= pwdata;
   end

   // Retirement runs one cycle behind the field update
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         retire_pend <= 1'b0;
      else
         retire_pend <= next_retire;
   end

   assign desc_in_use = status[SDSU_B_IN_USE];

   // ==========================================================
   // Config: valid, reload, isochronous, retry start value
   // ==========================================================
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         desc_valid <= 1'b0;
         reload     <= 4'h0;
         iso        <= 1'b0;
         retry_init <= SDSU_RST_RETRY;
      end
      else
      begin
         if (next_valid_drop)
            desc_valid <= 1'b0;
         else if (wr_en && paddr == SDSU_OFS_CONFIG)
            desc_valid <= pwdata[SDSU_B_VALID];
         if (wr_en && paddr == SDSU_OFS_CONFIG)
         begin
            reload <= pwdata[SDSU_B_RELOAD_HI:SDSU_B_RELOAD_LO];
            iso    <= pwdata[SDSU_B_ISO];
         end
         // Start value only follows a status write that actually lands
         if (wr_en && paddr == SDSU_OFS_STATUS && !(xr_done && desc_valid)
             && !retire_pend)
            retry_init <= pwdata[SDSU_B_RETRY_HI:SDSU_B_RETRY_LO];
      end
   end

   // ==========================================================
   // Retry pointer hold
   // ==========================================================
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         retry_pend     <= 1'b0;
         hold_async_ptr <= 1'b0;
      end
      else
      begin
         if (next_retry)
            retry_pend <= 1'b1;
         else if (xr_done || !desc_valid)
            retry_pend <= 1'b0;
         // Pending retry that ran out of frame time must go first next frame
         if (retry_pend && frame_short && desc_valid && !xr_done)
            hold_async_ptr <= 1'b1;
         // Released once the held retry has run, even if another one pends
         else if (!retry_pend || !desc_valid || xr_done)
            hold_async_ptr <= 1'b0;
         else if (frame_start && !frame_short)
            hold_async_ptr <= hold_async_ptr;
      end
   end

   // ==========================================================
   // Interrupts: sticky, write one to clear, set wins
   // ==========================================================
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq      <= 1'b0;
      end
      else
      begin
         if (wr_en && paddr == SDSU_OFS_IRQ_STAT)
            irq_stat <= (irq_stat & ~pwdata[SDSU_IRQ_W-1:0]) | next_events;
         else
            irq_stat <= irq_stat | next_events;
         if (wr_en && paddr == SDSU_OFS_IRQ_MASK)
            irq_mask <= pwdata[SDSU_IRQ_W-1:0];
         irq <= |(irq_stat & irq_mask);
      end
   end

endmodule : sdsu_top

`default_nettype wire

// >>> rtl/sdsu_pkg.sv
`default_nettype none
package sdsu_pkg;

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [7:0] SDSU_OFS_STATUS   = 8'h00;
   localparam logic [7:0] SDSU_OFS_CONFIG   = 8'h04;
   localparam logic [7:0] SDSU_OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] SDSU_OFS_IRQ_MASK = 8'h0c;

   // ==========================================================
   // Status word fields (descriptor bits 63..32 as bits 31..0)
   // ==========================================================
   localparam int SDSU_B_IN_USE   = 31;
   localparam int SDSU_B_STOP     = 30;
   localparam int SDSU_B_BABBLE   = 29;
   localparam int SDSU_B_XACT_ERR = 28;
   localparam int SDSU_B_PHASE    = 27;
   localparam int SDSU_B_TOGGLE   = 25;
   localparam int SDSU_B_RETRY_HI = 24;
   localparam int SDSU_B_RETRY_LO = 23;
   localparam int SDSU_B_NAK_HI   = 22;
   localparam int SDSU_B_NAK_LO   = 19;
   localparam int SDSU_B_BYTES_HI = 14;
   localparam int SDSU_B_BYTES_LO = 0;

   // Config register fields
   localparam int SDSU_B_VALID     = 0;
   localparam int SDSU_B_RELOAD_LO = 1;
   localparam int SDSU_B_RELOAD_HI = 4;
   localparam int SDSU_B_ISO       = 5;

   // Interrupt status / mask bit positions
   localparam int SDSU_IRQ_DONE     = 0;
   localparam int SDSU_IRQ_BABBLE   = 1;
   localparam int SDSU_IRQ_XACT_ERR = 2;
   localparam int SDSU_IRQ_HALT     = 3;
   localparam int SDSU_IRQ_NAK_OUT  = 4;
   localparam int SDSU_IRQ_W        = 5;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [31:0] SDSU_RST_STATUS = 32'h0000_0000;
   localparam logic [1:0]  SDSU_RST_RETRY  = 2'h3;

   // ==========================================================
   // Transaction outcome codes from the split engine
   // ==========================================================
   typedef enum logic [2:0] {
      SDSU_RES_ACK    = 3'b000,
      SDSU_RES_NAK    = 3'b001,
      SDSU_RES_NYET   = 3'b010,
      SDSU_RES_NORESP = 3'b011,
      SDSU_RES_BABBLE = 3'b100,
      SDSU_RES_STALL  = 3'b101
   } sdsu_res_t;

endpackage : sdsu_pkg
`default_nettype wire

// >>> sim/sdsu_hub_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdsu_hub_model
(
   // Clock
   input  wire logic        core_clk,
   // Result strobe toward the block
   output var  logic        xr_done,
   output var  logic [2:0]  xr_code,
   output var  logic [14:0] xr_bytes,
   output var  logic        xr_toggle,
   output var  logic        frame_start,
   output var  logic        frame_short
);
   initial
   begin
      {xr_done, xr_code, xr_bytes, xr_toggle} = '0;
      {frame_start, frame_short} = 2'b00;
   end

   // One result after gap cycles; lines scramble once the pulse is over
   task automatic send(input logic [2:0] c, input logic [14:0] b,
                       input logic t, input int gap);
      repeat (gap) @(posedge core_clk);
      {xr_done, xr_code, xr_bytes, xr_toggle} <= {1'b1, c, b, t};
      @(posedge core_clk);
      {xr_done, xr_code, xr_bytes, xr_toggle} <= {1'b0, ~c, ~b, ~t};
      repeat (3) @(posedge core_clk);
   endtask : send

   task automatic short_frame();
      {frame_start, frame_short} <= 2'b11;
      @(posedge core_clk);
      {frame_start, frame_short} <= 2'b00;
      repeat (2) @(posedge core_clk);
   endtask : short_frame
endmodule : sdsu_hub_model
`default_nettype wire

// >>> sim/sdsu_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sdsu_properties
   import sdsu_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // APB
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic       pready,
   input wire logic       pslverr,
   // Results
   input wire logic       xr_done,
   input wire logic [2:0] xr_code,
   input wire logic       frame_short,
   // Descriptor state and interrupt
   input wire logic       desc_valid,
   input wire logic       desc_in_use,
   input wire logic       hold_async_ptr,
   input wire logic       irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire logic taken = xr_done && desc_valid;
   wire logic wr_done = psel && penable && pready && pwrite;

   babble_retire_a: assert property (
      taken && xr_code == SDSU_RES_BABBLE |=> !desc_valid ##1 !desc_in_use)
      else $error("babble did not retire");
   end_retire_a: assert property (
      taken && (xr_code == SDSU_RES_ACK || xr_code == SDSU_RES_STALL)
      |=> !desc_valid ##1 !desc_in_use) else $error("no retirement");
   inuse_order_a: assert property (
      taken && desc_in_use |=> desc_in_use) else $error("in-use early");
   valid_cause_a: assert property (
      $fell(desc_valid) |-> $past(xr_done) || $past(wr_done))
      else $error("valid dropped without cause");
   irq_cause_a: assert property (
      $rose(irq) |-> $past(xr_done, 2) || $past(wr_done, 2))
      else $error("irq rose without cause");
   apb_wait_a: assert property (
      psel && penable && !pready |=> pready) else $error("wait state");
   apb_ready_a: assert property (
      pready || pslverr |-> pready && psel && penable ##1 !pready)
      else $error("bad ready pulse");
   hold_rise_a: assert property (
      $rose(hold_async_ptr) |-> $past(frame_short) && $past(desc_valid))
      else $error("hold rose without cause");
   hold_release_a: assert property (
      hold_async_ptr && (xr_done || !desc_valid) |-> ##[1:2] !hold_async_ptr)
      else $error("hold not released");

   cover property (taken && xr_code == SDSU_RES_NAK);
   cover property ($rose(hold_async_ptr));
   cover property ($rose(irq));
endmodule : sdsu_properties

bind sdsu_top sdsu_properties chk_u (
   .core_clk, .rstn, .psel, .penable, .pwrite, .pready, .pslverr, .xr_done,
   .xr_code, .frame_short, .desc_valid, .desc_in_use, .hold_async_ptr, .irq);
`default_nettype wire

// >>> sim/sdsu_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdsu_tb_top
   import sdsu_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, xr_done, xr_toggle;
   logic        frame_start, frame_short;
   logic [2:0]  xr_code;
   logic [14:0] xr_bytes;
   logic        desc_valid, desc_in_use, hold_async_ptr, irq;
   int          fail_count = 0, num_checks = 0, cycles = 0;

   initial forever #20 core_clk = ~core_clk;

   sdsu_top dut_u (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .xr_done, .xr_code, .xr_bytes,
      .xr_toggle, .frame_start, .frame_short, .desc_valid, .desc_in_use,
      .hold_async_ptr, .irq);
   sdsu_hub_model hub_u (.core_clk, .xr_done, .xr_code, .xr_bytes,
      .xr_toggle, .frame_start, .frame_short);

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge core_clk);
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask : rd_chk

   task automatic arm(input logic [31:0] m, c, s);
      apb(1'b1, SDSU_OFS_IRQ_STAT, 32'h1f);
      apb(1'b1, SDSU_OFS_IRQ_MASK, m);
      apb(1'b1, SDSU_OFS_STATUS, s);
      apb(1'b1, SDSU_OFS_CONFIG, c);
   endtask : arm

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd_chk(SDSU_OFS_STATUS, SDSU_RST_STATUS);
      rd_chk(SDSU_OFS_CONFIG, 32'h0);
      rd_chk(8'h10, 32'h0);
      check({31'h0, err}, 32'h1);
      check({28'h0, desc_valid, desc_in_use, hold_async_ptr, irq}, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ack;
      arm(32'h1, 32'h1, 32'h8380_0000);
      hub_u.send(SDSU_RES_ACK, 15'h7fff, 1'b0, 3);
      rd_chk(SDSU_OFS_STATUS, 32'h0180_7fff);
      check({31'h0, desc_valid}, 32'h0);
      check({31'h0, desc_in_use}, 32'h0);
      check({31'h0, irq}, 32'h1);
      rd_chk(SDSU_OFS_IRQ_STAT, 32'h1);
      apb(1'b1, SDSU_OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge core_clk);
      check({31'h0, irq}, 32'h0);
      $display("test ack done");
   endtask : t_ack

   task automatic t_noresp;
      arm(32'h4, 32'h1, 32'h8180_0000);
      hub_u.send(SDSU_RES_NORESP, 15'h0, 1'b0, 0);
      rd_chk(SDSU_OFS_STATUS, 32'h9100_0000);
      check({31'h0, irq}, 32'h1);
      check({31'h0, desc_in_use}, 32'h1);
      hub_u.short_frame();
      check({31'h0, hold_async_ptr}, 32'h1);
      hub_u.send(SDSU_RES_NYET, 15'h0, 1'b0, 0);
      check({31'h0, hold_async_ptr}, 32'h0);
      rd_chk(SDSU_OFS_STATUS, 32'h9180_0000);
      repeat (2) hub_u.send(SDSU_RES_NORESP, 15'h0, 1'b0, 0);
      rd_chk(SDSU_OFS_STATUS, 32'h9080_0000);
      check({31'h0, desc_valid}, 32'h1);
      hub_u.send(SDSU_RES_NORESP, 15'h0, 1'b0, 0);
      check({31'h0, desc_valid}, 32'h0);
      rd_chk(SDSU_OFS_STATUS, 32'h1000_0000);
      $display("test no response done");
   endtask : t_noresp

   task automatic t_nak;
      arm(32'h10, 32'h5, 32'h8190_0000);
      hub_u.send(SDSU_RES_NAK, 15'h0, 1'b0, 0);
      rd_chk(SDSU_OFS_STATUS, 32'h8188_0000);
      check({31'h0, desc_valid}, 32'h1);
      hub_u.send(SDSU_RES_NYET, 15'h0, 1'b0, 0);
      check({31'h0, desc_valid}, 32'h0);
      check({31'h0, irq}, 32'h1);
      rd_chk(SDSU_OFS_STATUS, 32'h0180_0000);
      arm(32'h0, 32'h25, 32'h8190_0000);
      hub_u.send(SDSU_RES_NAK, 15'h0, 1'b0, 0);
      rd_chk(SDSU_OFS_STATUS, 32'h8190_0000);
      check({31'h0, desc_valid}, 32'h1);
      $display("test nak done");
   endtask : t_nak

   task automatic t_bab_stall;
      arm(32'h2, 32'h1, 32'h8180_0000);
      hub_u.send(SDSU_RES_BABBLE, 15'h0040, 1'b1, 0);
      rd_chk(SDSU_OFS_STATUS, 32'h2180_0040);
      check({30'h0, desc_valid, irq}, 32'h1);
      arm(32'h2, 32'h1, 32'h8180_0000);
      hub_u.send(SDSU_RES_STALL, 15'h0123, 1'b0, 0);
      rd_chk(SDSU_OFS_STATUS, 32'h4180_0000);
      check({31'h0, irq}, 32'h0);
      $display("test babble stall done");
   endtask : t_bab_stall

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         fail_count++;
         finish_test;
      end
   end

   initial
   begin
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset;
      t_ack;
      t_noresp;
      t_nak;
      t_bab_stall;
      finish_test;
   end
endmodule : sdsu_tb_top
`default_nettype wire
